// ==== shared_bus_map.svh ====
// Constant map for the shared bus master: field positions, widths, lane figures and pin levels.
// Assumes it is included by bare name wherever these names are needed.
`ifndef SHARED_BUS_MAP_SVH
`define SHARED_BUS_MAP_SVH

`define DATA_W         64
`define ADDR_W         36
`define CTRL_W         28
`define ADDR_MSB       35
`define ADDR_LSB       0
`define CTRL_MSB       63
`define CTRL_LSB       36
`define BEAT_W         3
`define FIFO_DEPTH     8
`define PTR_W          3
`define CNT_W          4
`define OFF_W          3
`define SHIFT_W        6
`define LANE_BYTE_TOP  3'h7
`define LANE_HALF_TOP  3'h6
`define LANE_WORD_TOP  3'h4
`define LANE_NONE      3'h0
`define MASK_BYTE      64'h0000_0000_0000_00ff
`define MASK_HALF      64'h0000_0000_0000_ffff
`define MASK_WORD      64'h0000_0000_ffff_ffff
`define MASK_DWORD     64'hffff_ffff_ffff_ffff
`define PIN_ASSERT     1'b0
`define PIN_DEASSERT   1'b1
`define BEAT_ZERO      3'h0
`define BEAT_ONE       3'h1

`endif

// ==== shared_bus_pkg.sv ====
// Types shared by the bus master and its helpers.
// Assumes the constant map header is found by bare name.
`include "shared_bus_map.svh"
package shared_bus_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_PARK = 3'b100
  } state_t;

  // Codes are the raw pin levels in the order error, ready, retry.
  typedef enum logic [2:0] {
    ACK_IDLE    = 3'b111,
    ACK_RELQ    = 3'b110,
    ACK_DATA    = 3'b101,
    ACK_RSVD    = 3'b100,
    ACK_BUSERR  = 3'b011,
    ACK_TIMEOUT = 3'b010,
    ACK_UNCORR  = 3'b001,
    ACK_RETRY   = 3'b000
  } ack_t;

  typedef enum logic [1:0] {
    SZ_BYTE  = 2'b00,
    SZ_HALF  = 2'b01,
    SZ_WORD  = 2'b10,
    SZ_DWORD = 2'b11
  } size_t;

endpackage

// ==== data_fifo_if.sv ====
// Carrier between the bus master and its write-data FIFO.
// Assumes the owner never releases more words than the FIFO holds.
`timescale 1ns/1ps
`default_nettype none
interface data_fifo_if #(parameter int WIDTH = 64, parameter int DEPTH = 8);
  logic [WIDTH-1:0]           inData;
  logic                       inValid;
  logic                       inReady;
  logic [WIDTH-1:0]           outData;
  logic                       outValid;
  logic                       outReady;
  logic [$clog2(DEPTH)-1:0]   peek;
  logic [$clog2(DEPTH+1)-1:0] dropCount;
  logic [$clog2(DEPTH+1)-1:0] count;
  modport owner (output inData, inValid, outReady, peek, dropCount,
                 input inReady, outData, outValid, count);
  modport store (input inData, inValid, outReady, peek, dropCount,
                 output inReady, outData, outValid, count);
endinterface
`default_nettype wire

// ==== data_fifo.sv ====
// Write-data FIFO with peek by offset and release of several words at once.
// Assumes the owner keeps dropCount within count; words stay until released so a retry can replay them.
`timescale 1ns/1ps
`default_nettype none
module data_fifo #(parameter int WIDTH = 64, parameter int DEPTH = 8) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Storage side
  data_fifo_if.store fifo
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [CW-1:0]    count_r;
  logic             notFull_r;
  logic             push;
  logic [CW-1:0]    drop;
  logic [CW-1:0]    count_nxt;

  assign push      = fifo.inValid && notFull_r;
  assign drop      = fifo.outReady ? fifo.dropCount : '0;
  assign count_nxt = CW'(count_r + CW'(push) - drop);

  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wrPtr_r] <= fifo.inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_r   <= '0;
      rdPtr_r   <= '0;
      count_r   <= '0;
      notFull_r <= 1'b1;
    end else if (ce) begin
      wrPtr_r   <= PW'(wrPtr_r + PW'(push));
      rdPtr_r   <= PW'(rdPtr_r + drop);
      count_r   <= count_nxt;
      notFull_r <= count_nxt != CW'(DEPTH);
    end
  end

  assign fifo.inReady  = notFull_r;
  assign fifo.outValid = count_r != '0;
  assign fifo.outData  = mem[PW'(rdPtr_r + fifo.peek)];
  assign fifo.count    = count_r;
endmodule // data_fifo
`default_nettype wire

// ==== ack_decode.sv ====
// Decoder of the three acknowledgement pins into a code and action flags.
// Assumes the pins are sampled only while this master owns a transaction.
`timescale 1ns/1ps
`default_nettype none
module ack_decode (
  // Acknowledgement pins, active low
  input  wire logic                 ackErrorN,
  input  wire logic                 ackReadyN,
  input  wire logic                 ackRetryN,
  // Decoded result
  output var  shared_bus_pkg::ack_t code,
  output logic                      dataBeat,
  output logic                      reissue,
  output logic                      relinquish,
  output logic                      finish
);
  always_comb begin
    code       = shared_bus_pkg::ack_t'({ackErrorN, ackReadyN, ackRetryN}); // see RULE7
    dataBeat   = 1'b0;
    reissue    = 1'b0;
    relinquish = 1'b0;
    finish     = 1'b1; // see RULE11
    case (code)
      shared_bus_pkg::ACK_IDLE:    finish     = 1'b0; // see RULE13
      shared_bus_pkg::ACK_DATA: begin
        dataBeat = 1'b1; // see RULE8
        finish   = 1'b0;
      end
      shared_bus_pkg::ACK_RELQ:    relinquish = 1'b1; // see RULE9
      shared_bus_pkg::ACK_RETRY:   reissue    = 1'b1; // see RULE13
      // Bus error, timeout from the monitor, uncorrectable and reserved all end as failures.
      shared_bus_pkg::ACK_BUSERR:  finish     = 1'b1; // see RULE10
      shared_bus_pkg::ACK_TIMEOUT: finish     = 1'b1; // see RULE12
      default:                     finish     = 1'b1;
    endcase
  end
endmodule // ack_decode
`default_nettype wire

// ==== shared_bus_master.sv ====
// Bus master controller: request and grant, address cycle, data cycles, acknowledgement handling.
// Assumes synchronous pins, an external arbiter and a resolver that turns output enables into wire levels.
// Functional notes
// RULE1 - Address cycle carries 36-bit physical address low, control on upper lines.
// RULE2 - Narrow data at natural lane; even words upper half, odd words lower.
// RULE3 - Bytes numbered big-endian; byte 2 of odd word on bits 15 to 8.
// RULE4 - Unused data lanes of narrow reads are ignored.
// RULE5 - Address strobe only in first cycle of each transaction attempt.
// RULE6 - After any retry, reissue with fresh strobe until data or error.
// RULE7 - Control pins are active low, true at logic zero.
// RULE8 - Ready alone means one valid data word this cycle.
// RULE9 - Retry alone aborts at once, releases bus, restarts later.
// RULE10 - Error alone reports a bus or system error.
// RULE11 - Any non-data acknowledgement ends the transaction immediately.
// RULE12 - Slave drives acknowledgements; timeout comes from the bus monitor.
// RULE13 - Idle, reserved, timeout, uncorrectable and retry-without-relinquish codes decoded.
// RULE14 - Each master requests on its own dedicated request line.
// RULE15 - Arbiter grants on the chosen master's dedicated grant line.
// RULE16 - Busy held from strobe through last ready or first terminating acknowledgement.
// RULE17 - Back-to-back transactions keep busy asserted; busy locks arbitration. A parked write whose beats are not all buffered drops busy and goes to ST_ARB.
// RULE18 - Granted master takes the bus first cycle after busy released; a write stays in ST_ARB until all its beats are buffered.
// RULE19 - Busy may be asserted before strobe to hold the bus.
// RULE20 - Busy past final acknowledgement only while grant parked; strobe within 2 cycles.
// RULE21 - Module reset returns logic to initial state, outputs inactive or released.
`timescale 1ns/1ps
`default_nettype none
`include "shared_bus_map.svh"
module shared_bus_master (
  // Clock, reset and enable
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // Command port
  input  wire logic                  cmdValid,
  output logic                       cmdReady,
  input  wire logic [`ADDR_W-1:0]    cmdAddr,
  input  wire logic [`CTRL_W-1:0]    cmdCtrl,
  input  wire logic                  cmdWrite,
  input  wire shared_bus_pkg::size_t cmdSize,
  input  wire logic [`BEAT_W-1:0]    cmdBeats,
  // Write data stream
  input  wire logic [`DATA_W-1:0]    wrData,
  input  wire logic                  wrValid,
  output logic                       wrReady,
  // Read data stream
  output logic [`DATA_W-1:0]         rdData,
  output logic                       rdValid,
  // Completion
  output logic                       doneValid,
  output var  shared_bus_pkg::ack_t  doneStatus,
  // Shared address and data lines
  input  wire logic [`DATA_W-1:0]    sharedAddrDataIn,
  output logic [`DATA_W-1:0]         sharedAddrDataOut,
  output logic                       sharedAddrDataOe,
  // Address strobe
  output logic                       addrStrobeN,
  output logic                       addrStrobeOe,
  // Acknowledgement lines
  input  wire logic                  ackReadyN,
  input  wire logic                  ackRetryN,
  input  wire logic                  ackErrorN,
  // Arbitration
  output logic                       busRequestN,
  input  wire logic                  busGrantN,
  input  wire logic                  busBusyNIn,
  output logic                       busBusyNOut,
  output logic                       busBusyOe
);

  shared_bus_pkg::state_t state_r;
  shared_bus_pkg::state_t state_nxt;
  logic [`ADDR_W-1:0]     addr_r;
  logic [`CTRL_W-1:0]     ctrl_r;
  logic                   write_r;
  shared_bus_pkg::size_t  size_r;
  logic [`BEAT_W-1:0]     beatsLast_r;
  logic [`BEAT_W-1:0]     beatCnt_r;
  logic                   cmdReady_r;
  logic [`DATA_W-1:0]     busOut_r;
  logic                   busOe_r;
  logic                   strobeN_r;
  logic                   strobeOe_r;
  logic                   requestN_r;
  logic                   busyN_r;
  logic                   busyOe_r;
  logic [`DATA_W-1:0]     rdData_r;
  logic                   rdValid_r;
  logic                   doneValid_r;
  shared_bus_pkg::ack_t   doneStatus_r;

  shared_bus_pkg::ack_t   ackCode;
  logic                   ackData;
  logic                   ackReissue;
  logic                   ackRelinquish;
  logic                   ackFinish;
  logic                   inData;
  logic                   beatOk;
  logic                   lastBeat;
  logic                   doneNow;
  logic                   cmdTake;
  logic                   dataReady;
  logic                   newReady;
  logic                   loadWord;
  shared_bus_pkg::size_t  laneSize;
  logic [`SHIFT_W-1:0]    shift;
  logic [`DATA_W-1:0]     mask;
  logic [`DATA_W-1:0]     addrWord;

  data_fifo_if #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) wfifo ();

  data_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .fifo    (wfifo.store)
  );

  ack_decode u_ack (
    .ackErrorN  (ackErrorN),
    .ackReadyN  (ackReadyN),
    .ackRetryN  (ackRetryN),
    .code       (ackCode),
    .dataBeat   (ackData),
    .reissue    (ackReissue),
    .relinquish (ackRelinquish),
    .finish     (ackFinish)
  );

  // Lane position from the top of the bus, counted in bytes, then scaled to bits.
  function automatic logic [`SHIFT_W-1:0] laneShift(input logic [`OFF_W-1:0] off,
                                                    input shared_bus_pkg::size_t sz);
    logic [`OFF_W-1:0] lanes;
    lanes = `LANE_NONE;
    case (sz)
      shared_bus_pkg::SZ_BYTE: lanes = `OFF_W'(`LANE_BYTE_TOP - off); // see RULE3
      shared_bus_pkg::SZ_HALF: lanes = `OFF_W'(`LANE_HALF_TOP - {off[2:1], 1'b0});
      shared_bus_pkg::SZ_WORD: lanes = `OFF_W'(`LANE_WORD_TOP - {off[2], 2'b00}); // see RULE2
      default:                 lanes = `LANE_NONE;
    endcase
    return {lanes, 3'b000};
  endfunction

  function automatic logic [`DATA_W-1:0] laneMask(input shared_bus_pkg::size_t sz);
    logic [`DATA_W-1:0] m;
    m = `MASK_DWORD;
    case (sz)
      shared_bus_pkg::SZ_BYTE: m = `MASK_BYTE;
      shared_bus_pkg::SZ_HALF: m = `MASK_HALF;
      shared_bus_pkg::SZ_WORD: m = `MASK_WORD;
      default:                 m = `MASK_DWORD;
    endcase
    return m;
  endfunction

  // Bursts always move whole doublewords, so steering applies to single beats only.
  assign laneSize  = (beatsLast_r != `BEAT_ZERO) ? shared_bus_pkg::SZ_DWORD : size_r;
  assign shift     = laneShift(addr_r[`OFF_W-1:0], laneSize);
  assign mask      = laneMask(laneSize);

  // Acknowledgements from other masters' slaves are ignored outside our data phase.
  assign inData    = (state_r == shared_bus_pkg::ST_DATA);
  assign beatOk    = inData && ackData;
  assign lastBeat  = beatCnt_r == beatsLast_r;
  assign doneNow   = (beatOk && lastBeat) || (inData && ackFinish && !ackReissue && !ackRelinquish);
  assign cmdTake   = cmdValid && cmdReady_r;

  // A write starts only when every beat is already buffered, because the bus cannot be stalled.
  assign dataReady = !write_r || (wfifo.count > {1'b0, beatsLast_r});
  assign newReady  = !cmdWrite || (wfifo.count > {1'b0, cmdBeats});
  assign addrWord  = (state_r == shared_bus_pkg::ST_PARK) ? {cmdCtrl, cmdAddr} : {ctrl_r, addr_r};

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      shared_bus_pkg::ST_IDLE: begin
        if (cmdTake) begin
          state_nxt = shared_bus_pkg::ST_ARB;
        end
      end
      shared_bus_pkg::ST_ARB: begin
        if (!busGrantN && busBusyNIn && dataReady) begin
          state_nxt = shared_bus_pkg::ST_ADDR; // see RULE18
        end
      end
      shared_bus_pkg::ST_ADDR: state_nxt = shared_bus_pkg::ST_DATA;
      shared_bus_pkg::ST_DATA: begin
        if (beatOk && lastBeat) begin
          state_nxt = !busGrantN ? shared_bus_pkg::ST_PARK : shared_bus_pkg::ST_IDLE; // see RULE20
        end else if (inData && ackReissue) begin
          state_nxt = shared_bus_pkg::ST_ADDR; // see RULE6
        end else if (inData && ackRelinquish) begin
          state_nxt = shared_bus_pkg::ST_ARB; // see RULE9
        end else if (inData && ackFinish) begin
          state_nxt = shared_bus_pkg::ST_IDLE; // see RULE11
        end
      end
      shared_bus_pkg::ST_PARK: begin
        // One parked cycle keeps the next strobe within two cycles of the final acknowledgement.
        if (cmdTake) begin
          state_nxt = newReady ? shared_bus_pkg::ST_ADDR : shared_bus_pkg::ST_ARB; // see RULE17
        end else begin
          state_nxt = shared_bus_pkg::ST_IDLE;
        end
      end
      default: state_nxt = shared_bus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= shared_bus_pkg::ST_IDLE; // see RULE21
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_r      <= '0;
      ctrl_r      <= '0;
      write_r     <= 1'b0;
      size_r      <= shared_bus_pkg::SZ_DWORD;
      beatsLast_r <= `BEAT_ZERO;
    end else if (ce && cmdTake) begin
      addr_r      <= cmdAddr;
      ctrl_r      <= cmdCtrl;
      write_r     <= cmdWrite;
      size_r      <= cmdSize;
      beatsLast_r <= cmdBeats;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmdReady_r <= 1'b0;
    end else if (ce) begin
      cmdReady_r <= (state_nxt == shared_bus_pkg::ST_IDLE) || (state_nxt == shared_bus_pkg::ST_PARK);
    end
  end

  // Beat counter restarts on every attempt, so a retried write replays from its first word.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      beatCnt_r <= `BEAT_ZERO;
    end else if (ce) begin
      if (state_nxt == shared_bus_pkg::ST_ADDR) begin
        beatCnt_r <= `BEAT_ZERO;
      end else if (beatOk) begin
        beatCnt_r <= `BEAT_W'(beatCnt_r + `BEAT_ONE);
      end
    end
  end

  assign wfifo.inData    = wrData;
  assign wfifo.inValid   = wrValid;
  assign wfifo.peek      = (state_r == shared_bus_pkg::ST_ADDR) ? `PTR_W'(0) : `PTR_W'(beatCnt_r + `BEAT_ONE);
  assign wfifo.outReady  = doneNow && write_r;
  assign wfifo.dropCount = `CNT_W'({1'b0, beatsLast_r} + `CNT_W'(1));
  assign loadWord        = (state_nxt == shared_bus_pkg::ST_DATA) && write_r
                           && ((state_r == shared_bus_pkg::ST_ADDR) || beatOk);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busOut_r <= '0;
      busOe_r  <= 1'b0;
    end else if (ce) begin
      if (state_nxt == shared_bus_pkg::ST_ADDR) begin
        busOut_r <= addrWord; // see RULE1
        busOe_r  <= 1'b1;
      end else if (loadWord) begin
        busOut_r <= (wfifo.outData & mask) << shift; // see RULE2
        busOe_r  <= 1'b1;
      end else begin
        busOe_r  <= (state_nxt == shared_bus_pkg::ST_DATA) && write_r;
      end
    end
  end

  // Strobe is driven high in the data and park cycles and busy is driven low while owning so the bussed lines never float between beats.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strobeN_r  <= `PIN_DEASSERT;
      strobeOe_r <= 1'b0;
    end else if (ce) begin
      strobeN_r  <= (state_nxt == shared_bus_pkg::ST_ADDR) ? `PIN_ASSERT : `PIN_DEASSERT; // see RULE5
      strobeOe_r <= (state_nxt == shared_bus_pkg::ST_ADDR) || (state_nxt == shared_bus_pkg::ST_DATA)
                    || (state_nxt == shared_bus_pkg::ST_PARK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busyN_r  <= `PIN_DEASSERT;
      busyOe_r <= 1'b0;
    end else if (ce) begin
      if ((state_nxt == shared_bus_pkg::ST_ADDR) || (state_nxt == shared_bus_pkg::ST_DATA)
          || (state_nxt == shared_bus_pkg::ST_PARK)) begin
        busyN_r  <= `PIN_ASSERT; // see RULE16
        busyOe_r <= 1'b1; // see RULE19
      end else begin
        busyN_r  <= `PIN_DEASSERT;
        busyOe_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      requestN_r <= `PIN_DEASSERT;
    end else if (ce) begin
      requestN_r <= (state_nxt == shared_bus_pkg::ST_ARB) ? `PIN_ASSERT : `PIN_DEASSERT; // see RULE14
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_r  <= '0;
      rdValid_r <= 1'b0;
    end else if (ce) begin
      rdValid_r <= beatOk && !write_r;
      if (beatOk && !write_r) begin
        rdData_r <= (sharedAddrDataIn >> shift) & mask; // see RULE4
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      doneValid_r  <= 1'b0;
      doneStatus_r <= shared_bus_pkg::ACK_IDLE;
    end else if (ce) begin
      doneValid_r <= doneNow;
      if (doneNow) begin
        doneStatus_r <= ackCode; // see RULE10
      end
    end
  end

  assign cmdReady          = cmdReady_r;
  assign wrReady           = wfifo.inReady;
  assign rdData            = rdData_r;
  assign rdValid           = rdValid_r;
  assign doneValid         = doneValid_r;
  assign doneStatus        = doneStatus_r;
  assign sharedAddrDataOut = busOut_r;
  assign sharedAddrDataOe  = busOe_r;
  assign addrStrobeN       = strobeN_r;
  assign addrStrobeOe      = strobeOe_r;
  assign busRequestN       = requestN_r;
  assign busBusyNOut       = busyN_r;
  assign busBusyOe         = busyOe_r;

endmodule // shared_bus_master
`default_nettype wire

// ==== shared_bus_properties.sv ====
// Checker for the bus master's pin behaviour.
// Assumes it is bound to shared_bus_master and sees its ports by name.
`timescale 1ns/1ps
`default_nettype none
module shared_bus_properties (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Master pins
  input wire logic       addrStrobeN,
  input wire logic       addrStrobeOe,
  input wire logic       sharedAddrDataOe,
  input wire logic       busBusyNOut,
  input wire logic       busBusyOe,
  input wire logic       busRequestN,
  input wire logic       busGrantN,
  input wire logic       busBusyNIn,
  input wire logic       ackErrorN,
  input wire logic       ackReadyN,
  input wire logic       ackRetryN,
  input wire logic       rdValid,
  input wire logic       doneValid,
  input wire logic [2:0] doneStatus
);
  logic [2:0] ackNow;
  logic       inData;
  assign ackNow = {ackErrorN, ackReadyN, ackRetryN};
  // Also true in the park cycle, where acknowledgements stay idle.
  assign inData = addrStrobeOe & addrStrobeN;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence take_bus; !busRequestN && !busGrantN && busBusyNIn; endsequence
  sequence addr_cycle; !addrStrobeN && sharedAddrDataOe && busBusyOe && !busBusyNOut; endsequence
  strobe_single_a: assert property (!addrStrobeN |=> addrStrobeN) else $error("strobe held");
  addr_drive_a: assert property (!addrStrobeN |-> addr_cycle) else $error("address cycle");
  take_bus_a: assert property (take_bus |=> addr_cycle) else $error("late ownership");
  bus_locked_a: assert property (!busRequestN && !busBusyNIn && !busBusyOe |=> addrStrobeN)
    else $error("strobe while locked");
  relq_release_a: assert property (inData && ackNow == 3'h6 |=> !busBusyOe && !addrStrobeOe && !doneValid)
    else $error("no release");
  retry_again_a: assert property (inData && ackNow == 3'h0 |=> !addrStrobeN && busBusyOe)
    else $error("no reissue");
  error_end_a: assert property (inData && ackNow inside {3'h1, 3'h2, 3'h3, 3'h4}
    |=> doneValid && doneStatus == $past(ackNow) && !addrStrobeOe) else $error("error not ended");
  read_beat_a: assert property (inData && ackNow == 3'h5 && !sharedAddrDataOe |=> rdValid)
    else $error("beat lost");
  busy_hold_a: assert property (inData |-> busBusyOe && !busBusyNOut) else $error("busy dropped");
  reset_idle_a: assert property ($fell(rst) |-> !addrStrobeOe && !busBusyOe && busRequestN)
    else $error("outputs active in reset");
endmodule // shared_bus_properties
bind shared_bus_master shared_bus_properties chk (.*);
`default_nettype wire

// ==== bus_slave_model.sv ====
// Behavioural slave, parking arbiter and bus wire resolution facing one master.
// Assumes the bench sets the first acknowledgement code, beat count and read word.
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
  // Clock, reset and scenario control
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [2:0]  firstCode,
  input wire logic [2:0]  cmdBeats,
  input wire logic [63:0] rdWord,
  input wire logic        park,
  input wire logic        holdBusy,
  // Master pins
  input wire logic        busRequestN,
  input wire logic        addrStrobeN,
  input wire logic        addrStrobeOe,
  input wire logic [63:0] sharedAddrDataOut,
  input wire logic        sharedAddrDataOe,
  input wire logic        busBusyNOut,
  input wire logic        busBusyOe,
  // Resolved lines and observations
  output logic            busGrantN,
  output logic            busBusyNIn,
  output logic [63:0]     sharedAddrDataIn,
  output logic [2:0]      ack,
  output logic [63:0]     addrCap,
  output logic [63:0]     wrCap,
  output logic [3:0]      beats
);
  logic        retried;
  logic [2:0]  left;
  logic [63:0] noise;
  assign busGrantN = busRequestN & ~park;
  assign busBusyNIn = (busBusyOe ? busBusyNOut : 1'h1) & ~holdBusy;
  // Released lines carry the read word during a data acknowledgement and noise otherwise, never a stale value.
  assign sharedAddrDataIn = sharedAddrDataOe ? sharedAddrDataOut : (ack == 3'h5 ? rdWord : noise);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack <= 3'h7;
      left <= '0;
      retried <= 1'h0;
      beats <= 4'h0;
      noise <= 64'h0123_4567_89ab_cdef;
      addrCap <= '0;
      wrCap <= '0;
    end else begin
      noise <= {noise[62:0], ~noise[63]};
      if (!addrStrobeN && addrStrobeOe) begin
        addrCap <= sharedAddrDataIn;
        beats <= 4'h0;
        if (!retried && firstCode != 3'h5) begin
          ack <= firstCode;
          retried <= (firstCode == 3'h6 || firstCode == 3'h0);
        end else begin
          ack <= 3'h5;
          left <= cmdBeats;
          retried <= 1'h0;
        end
      end else if (ack == 3'h5 && left != '0) begin
        left <= left - 1'h1;
      end else begin
        ack <= 3'h7;
      end
      if (ack == 3'h5) begin
        beats <= beats + 4'h1;
        wrCap <= sharedAddrDataIn;
      end
    end
  end
endmodule // bus_slave_model
`default_nettype wire

// ==== shared_bus_module_port_tb.sv ====
// Self-checking bench for the bus master against a behavioural slave and arbiter.
// Assumes the master's ports as declared; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module shared_bus_module_port_tb;
  logic clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, cmdValid = 1'h0, cmdWrite = 1'h0, wrValid = 1'h0;
  logic park = 1'h0, holdBusy = 1'h0;
  logic [35:0] cmdAddr = 36'h0;
  logic [27:0] cmdCtrl = 28'h5a5_c3e1;
  logic [2:0] cmdBeats = 3'h0, firstCode = 3'h5, ack;
  logic [63:0] wrData = 64'h0, rdWord = 64'h0011_2233_4455_6677, rdData, sharedAddrDataIn, sharedAddrDataOut;
  logic [63:0] addrCap, wrCap;
  logic [3:0] beats;
  logic cmdReady, wrReady, rdValid, doneValid, sharedAddrDataOe, addrStrobeN, addrStrobeOe;
  logic ackReadyN, ackRetryN, ackErrorN, busRequestN, busGrantN, busBusyNIn, busBusyNOut, busBusyOe;
  shared_bus_pkg::size_t cmdSize = shared_bus_pkg::SZ_BYTE;
  shared_bus_pkg::ack_t doneStatus;
  int err_count = 0, num_checks = 0, cycles = 0;
  assign {ackErrorN, ackReadyN, ackRetryN} = ack;
  shared_bus_master DUT (.*);
  bus_slave_model model (.*);
  always #25 clk_sys = ~clk_sys;
  // A stuck handshake ends the run here.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [63:0] w);
    wrData = w;
    wrValid = 1'h1;
    @(negedge clk_sys);
    wrValid = 1'h0;
    @(negedge clk_sys);
  endtask
  task automatic run(input logic [35:0] a, input logic w, input logic [1:0] s, input logic [2:0] b,
                     input logic [2:0] code);
    int n;
    cmdAddr = a;
    cmdWrite = w;
    cmdSize = shared_bus_pkg::size_t'(s);
    cmdBeats = b;
    firstCode = code;
    cmdValid = 1'h1;
    while (cmdReady !== 1'h1) @(negedge clk_sys);
    @(negedge clk_sys);
    cmdValid = 1'h0;
    for (n = 0; n < 100 && doneValid !== 1'h1; n++) @(negedge clk_sys);
    chk(doneValid, 64'h1);
  endtask
  task automatic t_lanes();
    chk({addrStrobeOe, busBusyOe, sharedAddrDataOe, busRequestN, addrStrobeN, busBusyNOut, wrReady, doneStatus},
        64'h7f);
    run(36'h1_2345_6786, 1'h0, 2'h0, 3'h0, 3'h5);
    chk(addrCap, {cmdCtrl, 36'h1_2345_6786});
    chk(rdData, (rdWord >> 8) & 64'hff);
    run(36'h10, 1'h0, 2'h2, 3'h0, 3'h5);
    chk(rdData, rdWord >> 32);
    push(64'hcafe_f00d);
    run(36'h24, 1'h1, 2'h2, 3'h0, 3'h5);
    chk(wrCap & 64'hffff_ffff, 64'hcafe_f00d);
    push(64'h5a);
    run(36'h6, 1'h1, 2'h0, 3'h0, 3'h5);
    chk(wrCap & 64'hff00, 64'h5a00);
    for (int i = 1; i < 5; i++) push(64'h1111_1111_1111_1111 * i);
    run(36'h40, 1'h1, 2'h3, 3'h3, 3'h5);
    chk({beats, wrCap}, {4'h4, 64'h4444_4444_4444_4444});
  endtask
  task automatic t_codes();
    logic [2:0] codes [6] = '{3'h6, 3'h0, 3'h3, 3'h2, 3'h1, 3'h4};
    foreach (codes[i]) begin
      run(36'h8, 1'h0, 2'h3, 3'h3, codes[i]);
      if (codes[i] == 3'h6 || codes[i] == 3'h0)
        chk({doneStatus, beats}, {3'h5, 4'h4});
      else
        chk({doneStatus, beats}, {codes[i], 4'h0});
    end
  endtask
  task automatic t_arbitration();
    holdBusy = 1'h1;
    fork
      run(36'h18, 1'h0, 2'h3, 3'h0, 3'h5);
      begin
        repeat (6) @(negedge clk_sys);
        chk(addrStrobeOe, 64'h0);
        holdBusy = 1'h0;
      end
    join
    chk(doneStatus, 64'h5);
    park = 1'h1;
    run(36'h20, 1'h0, 2'h3, 3'h0, 3'h5);
    chk({busBusyOe, busBusyNOut, cmdReady}, 64'h5);
    run(36'h28, 1'h0, 2'h3, 3'h0, 3'h5);
    chk(addrCap[35:0], 64'h28);
    park = 1'h0;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'h0;
    @(negedge clk_sys);
    t_lanes();
    t_codes();
    t_arbitration();
    close_out();
  end
endmodule // shared_bus_module_port_tb
`default_nettype wire
